// ==== cfp_pkg.sv ====
package cfp_pkg;
    localparam int PC_W = 21;
    localparam logic [20:0] PC_RST = 21'h000000;
    localparam logic [20:0] PC_STEP = 21'h000002;
    localparam logic [3:0] WORD2_TAG = 4'hF;
    localparam logic [7:0] ADR_PCLOW = 8'h00;
    localparam logic [7:0] ADR_HLAT = 8'h04;
    localparam logic [7:0] ADR_ULAT = 8'h08;
    localparam logic [7:0] ADR_CTRL = 8'h0C;
    localparam logic [7:0] ADR_STAT = 8'h10;
    localparam logic [7:0] HLAT_RST = 8'h00;
    localparam logic [4:0] ULAT_RST = 5'h00;
    localparam logic CTRL_RUN_RST = 1'h1;
    localparam logic [7:0] SHADOW_RST = 8'h00;
    localparam logic [15:0] INSTR_RST = 16'h0000;

    typedef enum logic [3:0] {
        PH_Q1 = 4'b0001,
        PH_Q2 = 4'b0010,
        PH_Q3 = 4'b0100,
        PH_Q4 = 4'b1000
    } cfp_phase_t;

    typedef enum logic [1:0] {
        BR_NONE = 2'h0,
        BR_ABS = 2'h1,
        BR_REL = 2'h2
    } cfp_br_t;

    function automatic logic cfp_hit(input logic [7:0] adr, input logic [7:0] off);
        return adr[7:2] == off[7:2];
    endfunction : cfp_hit
endpackage : cfp_pkg

// ==== cfp_shadow_if.sv ====
`timescale 1ns/1ps
interface cfp_shadow_if;
    logic save;
    logic restore;
    logic [7:0] inStatus;
    logic [7:0] inWreg;
    logic [7:0] inBsr;
    logic [7:0] outStatus;
    logic [7:0] outWreg;
    logic [7:0] outBsr;
    logic restored;

    modport core (
        output save, restore, inStatus, inWreg, inBsr,
        input outStatus, outWreg, outBsr, restored
    );
    modport store (
        input save, restore, inStatus, inWreg, inBsr,
        output outStatus, outWreg, outBsr, restored
    );
endinterface : cfp_shadow_if

// ==== cfp_shadow_store.sv ====
`timescale 1ns/1ps
module cfp_shadow_store (
    input wire logic clk_sys,
    input wire logic arst_n,
    cfp_shadow_if.store sh
);
    logic [7:0] shStatus_ff;
    logic [7:0] shWreg_ff;
    logic [7:0] shBsr_ff;
    logic [7:0] outStatus_ff;
    logic [7:0] outWreg_ff;
    logic [7:0] outBsr_ff;
    logic restored_ff;

    // one entry only: a later save simply overwrites the earlier one
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            shStatus_ff <= cfp_pkg::SHADOW_RST;
            shWreg_ff <= cfp_pkg::SHADOW_RST;
            shBsr_ff <= cfp_pkg::SHADOW_RST;
        end else if (sh.save) begin
            shStatus_ff <= sh.inStatus;
            shWreg_ff <= sh.inWreg;
            shBsr_ff <= sh.inBsr;
        end
    end

    // restore reads the old entry even when a save lands on the same edge
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            outStatus_ff <= cfp_pkg::SHADOW_RST;
            outWreg_ff <= cfp_pkg::SHADOW_RST;
            outBsr_ff <= cfp_pkg::SHADOW_RST;
            restored_ff <= 1'h0;
        end else begin
            restored_ff <= sh.restore;
            if (sh.restore) begin
                outStatus_ff <= shStatus_ff;
                outWreg_ff <= shWreg_ff;
                outBsr_ff <= shBsr_ff;
            end
        end
    end

    assign sh.outStatus = outStatus_ff;
    assign sh.outWreg = outWreg_ff;
    assign sh.outBsr = outBsr_ff;
    assign sh.restored = restored_ff;

    property p_shadowSave;
        @(posedge clk_sys) disable iff (!arst_n)
        sh.save |=> shStatus_ff == $past(sh.inStatus) && shBsr_ff == $past(sh.inBsr);
    endproperty
    a_shadowSave: assert property (p_shadowSave)
        else $error("shadow store missed a save");

    property p_shadowRestore;
        @(posedge clk_sys) disable iff (!arst_n)
        sh.restore |=> sh.restored && sh.outWreg == $past(shWreg_ff);
    endproperty
    a_shadowRestore: assert property (p_shadowRestore)
        else $error("fast return gave wrong working value");
endmodule : cfp_shadow_store

// ==== cfp_fetch_core.sv ====
`timescale 1ns/1ps
// Operation
// - a one-entry shadow saves status, working and bank select on interrupt entry
// - a fast return copies the shadowed values back to the working registers
// - software can neither read nor write the shadow store
// - every interrupt entry saves, so a nested entry overwrites the old copy
// - a fast call also saves status, working and bank select into the shadow
// - the program counter is 21 bits, byte addressed, bit 0 always zero
// - sequential fetch advances the program counter by two
// - only the low counter byte is accessible; upper bytes go through latches
// - writing the low byte loads the upper bytes from their latches
// - reading the low byte copies the upper bytes into their latches
// - calls, jumps and branches load the counter directly, bypassing the latches
// - the clock is divided into four ordered phases per instruction cycle
// - counter increments in Q1; fetched word is latched in Q4
// - execution spans Q1 to Q4: operand read in Q2, result written in Q4
// - fetch overlaps execution; a counter change flushes the fetched word
// - instructions are two or four bytes, each word starting at an even address
// - absolute call and jump targets are word addresses placed in bits 20:1
// - relative branch offsets count instruction words, not bytes
// - second words carry ones in the top four bits and 12 data bits
// - a second word executed without its first word acts as no operation
module cfp_fetch_core (
    input wire logic clk_sys,
    input wire logic arst_n,
    input wire logic wb_cyc,
    input wire logic wb_stb,
    input wire logic wb_we,
    input wire logic [7:0] wb_adr,
    input wire logic [3:0] wb_sel,
    input wire logic [31:0] wb_dat_w,
    output logic [31:0] wb_dat_r,
    output logic wb_ack,
    output logic [20:0] pmAddr,
    input wire logic [15:0] pmData,
    output logic [3:0] phase,
    output logic [15:0] instrRegister,
    output logic execValid,
    output logic [11:0] operandData,
    output logic operandValid,
    output logic dmRdStrobe,
    output logic dmWrStrobe,
    input wire cfp_pkg::cfp_br_t exBranchKind,
    input wire logic [19:0] exTargetWord,
    input wire logic [10:0] exRelWords,
    input wire logic exTwoWord,
    input wire logic exSkip,
    input wire logic exCallFast,
    input wire logic exRetFast,
    input wire logic intEntry,
    input wire logic [19:0] intVectorWord,
    input wire logic [7:0] curStatus,
    input wire logic [7:0] curWorkingAccumulator,
    input wire logic [7:0] curBankSelectReg,
    output logic fastRestore,
    output logic [7:0] restoreStatus,
    output logic [7:0] restoreWorkingAccumulator,
    output logic [7:0] restoreBankSelectReg
);
    cfp_pkg::cfp_phase_t phase_ff;
    logic [20:0] pc_ff;
    logic [20:0] nxt_pc;
    logic [7:0] pcHighLatch_ff;
    logic [4:0] pcUpperLatch_ff;
    logic ctrlRun_ff;
    logic [31:0] wbDatR_ff;
    logic wbAck_ff;
    logic [20:0] pmAddr_ff;
    logic fetchValid_ff;
    logic killFetch_ff;
    logic [15:0] instrRegister_ff;
    logic execValid_ff;
    logic operandCyc_ff;
    logic [11:0] operandData_ff;
    logic dmRd_ff;
    logic dmWr_ff;

    logic busAcc;
    logic busPcWr;
    logic busPcRd;
    logic isQ1;
    logic isQ4;
    logic execLive;
    logic takeBranch;
    logic intTake;
    logic flush;
    logic firstOfPair;
    logic orphanWord;
    logic [20:0] relTarget;

    cfp_shadow_if shIf ();

    cfp_shadow_store u_shadow (
        .clk_sys(clk_sys),
        .arst_n(arst_n),
        .sh(shIf.store)
    );

    assign isQ1 = phase_ff == cfp_pkg::PH_Q1;
    assign isQ4 = phase_ff == cfp_pkg::PH_Q4;

    // a request is served once; ack drops the cycle after it was given
    assign busAcc = wb_cyc && wb_stb && !wbAck_ff;
    assign busPcWr = busAcc && wb_we && wb_sel[0] && cfp_pkg::cfp_hit(wb_adr, cfp_pkg::ADR_PCLOW);
    assign busPcRd = busAcc && !wb_we && cfp_pkg::cfp_hit(wb_adr, cfp_pkg::ADR_PCLOW);

    // the second-word operand cycle may still carry the branch of its pair
    assign execLive = execValid_ff || operandCyc_ff;
    assign takeBranch = isQ4 && execLive && exBranchKind != cfp_pkg::BR_NONE;
    assign intTake = isQ4 && intEntry;
    assign firstOfPair = execValid_ff && exTwoWord;
    assign orphanWord = pmData[15:12] == cfp_pkg::WORD2_TAG && !firstOfPair;
    // pc already points two bytes past the next instruction at Q4 of execute
    assign relTarget = pc_ff - cfp_pkg::PC_STEP
        + {{9{exRelWords[10]}}, exRelWords, 1'h0};
    // a bus write on the latching edge itself must also drop the word
    assign flush = takeBranch || intTake || killFetch_ff || busPcWr
        || (execValid_ff && exSkip);

    // shadow traffic is driven only by entry, fast call and fast return
    assign shIf.save = intTake || (isQ4 && execValid_ff && exCallFast);
    assign shIf.restore = isQ4 && execLive && exRetFast;
    assign shIf.inStatus = curStatus;
    assign shIf.inWreg = curWorkingAccumulator;
    assign shIf.inBsr = curBankSelectReg;

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            phase_ff <= cfp_pkg::PH_Q1;
        end else begin
            unique case (phase_ff)
                cfp_pkg::PH_Q1: phase_ff <= cfp_pkg::PH_Q2;
                cfp_pkg::PH_Q2: phase_ff <= cfp_pkg::PH_Q3;
                cfp_pkg::PH_Q3: phase_ff <= cfp_pkg::PH_Q4;
                cfp_pkg::PH_Q4: phase_ff <= cfp_pkg::PH_Q1;
                default: phase_ff <= cfp_pkg::PH_Q1;
            endcase
        end
    end

    // bus write of the low byte has priority: software expects its jump to stick
    always_comb begin
        nxt_pc = pc_ff;
        if (busPcWr) begin
            nxt_pc = {pcUpperLatch_ff, pcHighLatch_ff, wb_dat_w[7:1], 1'h0};
        end else if (intTake) begin
            nxt_pc = {intVectorWord, 1'h0};
        end else if (takeBranch && exBranchKind == cfp_pkg::BR_ABS) begin
            nxt_pc = {exTargetWord, 1'h0};
        end else if (takeBranch && exBranchKind == cfp_pkg::BR_REL) begin
            nxt_pc = {relTarget[20:1], 1'h0};
        end else if (isQ1 && ctrlRun_ff) begin
            nxt_pc = pc_ff + cfp_pkg::PC_STEP;
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            pc_ff <= cfp_pkg::PC_RST;
        end else begin
            pc_ff <= nxt_pc;
        end
    end

    // latches are only written by the bus or by a low-byte read
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            pcHighLatch_ff <= cfp_pkg::HLAT_RST;
            pcUpperLatch_ff <= cfp_pkg::ULAT_RST;
        end else if (busPcRd) begin
            pcHighLatch_ff <= pc_ff[15:8];
            pcUpperLatch_ff <= pc_ff[20:16];
        end else if (busAcc && wb_we && wb_sel[0]) begin
            if (cfp_pkg::cfp_hit(wb_adr, cfp_pkg::ADR_HLAT)) begin
                pcHighLatch_ff <= wb_dat_w[7:0];
            end
            if (cfp_pkg::cfp_hit(wb_adr, cfp_pkg::ADR_ULAT)) begin
                pcUpperLatch_ff <= wb_dat_w[4:0];
            end
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            ctrlRun_ff <= cfp_pkg::CTRL_RUN_RST;
        end else if (busAcc && wb_we && wb_sel[0]
            && cfp_pkg::cfp_hit(wb_adr, cfp_pkg::ADR_CTRL)) begin
            ctrlRun_ff <= wb_dat_w[0];
        end
    end

    // upper counter bytes are read only through their latches; the shadow store has no read path at all
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            wbAck_ff <= 1'h0;
            wbDatR_ff <= 32'h00000000;
        end else begin
            wbAck_ff <= busAcc;
            if (busAcc && !wb_we) begin
                if (cfp_pkg::cfp_hit(wb_adr, cfp_pkg::ADR_PCLOW)) begin
                    wbDatR_ff <= {24'h000000, pc_ff[7:0]};
                end else if (cfp_pkg::cfp_hit(wb_adr, cfp_pkg::ADR_HLAT)) begin
                    wbDatR_ff <= {24'h000000, pcHighLatch_ff};
                end else if (cfp_pkg::cfp_hit(wb_adr, cfp_pkg::ADR_ULAT)) begin
                    wbDatR_ff <= {27'h0, pcUpperLatch_ff};
                end else if (cfp_pkg::cfp_hit(wb_adr, cfp_pkg::ADR_CTRL)) begin
                    wbDatR_ff <= {31'h0, ctrlRun_ff};
                end else if (cfp_pkg::cfp_hit(wb_adr, cfp_pkg::ADR_STAT)) begin
                    wbDatR_ff <= {25'h0, operandCyc_ff, execValid_ff,
                        fetchValid_ff, phase_ff};
                end else begin
                    wbDatR_ff <= 32'h00000000;
                end
            end
        end
    end

    // a low-byte write outside Q4 leaves a stale word in flight; kill it at Q4
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            killFetch_ff <= 1'h0;
        end else if (busPcWr && !isQ4) begin
            killFetch_ff <= 1'h1;
        end else if (isQ4) begin
            killFetch_ff <= 1'h0;
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            pmAddr_ff <= cfp_pkg::PC_RST;
            fetchValid_ff <= 1'h0;
        end else if (isQ1) begin
            pmAddr_ff <= pc_ff;
            fetchValid_ff <= ctrlRun_ff;
        end
    end

    // the word latched at Q4 executes during the whole next cycle
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            instrRegister_ff <= cfp_pkg::INSTR_RST;
            execValid_ff <= 1'h0;
            operandCyc_ff <= 1'h0;
            operandData_ff <= 12'h000;
        end else if (isQ4) begin
            instrRegister_ff <= pmData;
            execValid_ff <= fetchValid_ff && !flush && !firstOfPair
                && !orphanWord;
            operandCyc_ff <= fetchValid_ff && !flush && firstOfPair;
            if (firstOfPair) begin
                operandData_ff <= pmData[11:0];
            end
        end
    end

    // strobes are set one edge early so they sit squarely in Q2 and Q4
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            dmRd_ff <= 1'h0;
            dmWr_ff <= 1'h0;
        end else begin
            dmRd_ff <= isQ1 && execValid_ff;
            dmWr_ff <= phase_ff == cfp_pkg::PH_Q3 && execValid_ff;
        end
    end

    assign wb_dat_r = wbDatR_ff;
    assign wb_ack = wbAck_ff;
    assign pmAddr = pmAddr_ff;
    assign phase = phase_ff;
    assign instrRegister = instrRegister_ff;
    assign execValid = execValid_ff;
    assign operandData = operandData_ff;
    assign operandValid = operandCyc_ff;
    assign dmRdStrobe = dmRd_ff;
    assign dmWrStrobe = dmWr_ff;
    assign fastRestore = shIf.restored;
    assign restoreStatus = shIf.outStatus;
    assign restoreWorkingAccumulator = shIf.outWreg;
    assign restoreBankSelectReg = shIf.outBsr;

    default clocking @(posedge clk_sys);
    endclocking
    default disable iff (!arst_n);

    property p_pcAlign;
        pc_ff[0] == 1'h0 && pmAddr_ff[0] == 1'h0;
    endproperty
    a_pcAlign: assert property (p_pcAlign)
        else $error("program counter lost word alignment");

    property p_seqStep;
        isQ1 && ctrlRun_ff && !busPcWr |=> pc_ff == $past(pc_ff) + cfp_pkg::PC_STEP;
    endproperty
    a_seqStep: assert property (p_seqStep)
        else $error("sequential step is not two bytes");

    property p_phaseOrder;
        isQ1 |=> phase_ff == cfp_pkg::PH_Q2 ##1 phase_ff == cfp_pkg::PH_Q3
            ##1 phase_ff == cfp_pkg::PH_Q4 ##1 isQ1;
    endproperty
    a_phaseOrder: assert property (p_phaseOrder)
        else $error("phases out of order");

    property p_pclWrite;
        busPcWr |=> pc_ff[20:8] == $past({pcUpperLatch_ff, pcHighLatch_ff});
    endproperty
    a_pclWrite: assert property (p_pclWrite)
        else $error("low byte write did not load latches");

    property p_pclRead;
        busPcRd |=> pcHighLatch_ff == $past(pc_ff[15:8])
            && pcUpperLatch_ff == $past(pc_ff[20:16]);
    endproperty
    a_pclRead: assert property (p_pclRead)
        else $error("low byte read did not refresh latches");

    property p_absTarget;
        takeBranch && exBranchKind == cfp_pkg::BR_ABS && !busPcWr && !intTake
            |=> pc_ff == {$past(exTargetWord), 1'h0};
    endproperty
    a_absTarget: assert property (p_absTarget)
        else $error("absolute target not loaded as word address");

    property p_dmPhases;
        (dmRdStrobe |-> phase_ff == cfp_pkg::PH_Q2)
            and (dmWrStrobe |-> phase_ff == cfp_pkg::PH_Q4);
    endproperty
    a_dmPhases: assert property (p_dmPhases)
        else $error("data strobe in wrong phase");

    property p_flush;
        takeBranch |=> !execValid_ff && !operandCyc_ff;
    endproperty
    a_flush: assert property (p_flush)
        else $error("branch did not flush the fetched word");

    property p_orphanNop;
        isQ4 && orphanWord |=> !execValid_ff [*4];
    endproperty
    a_orphanNop: assert property (p_orphanNop)
        else $error("lone second word was executed");

    c_branch: cover property (takeBranch ##1 !execValid_ff);
    c_twoWord: cover property (isQ4 && firstOfPair ##1 operandCyc_ff);
    c_fastRestore: cover property (shIf.save ##[4:40] shIf.restore);
    c_pclWrite: cover property (busPcWr ##1 wb_ack);
endmodule : cfp_fetch_core

// ==== cfp_pmem_model.sv ====
`timescale 1ns/1ps
module cfp_pmem_model (
    input wire logic [20:0] pmAddr,
    output logic [15:0] pmData
);
    // read is combinational; bit 0 is ignored because every word sits at an even address
    always_comb begin
        // top bit kept low so filler words never carry the second-word tag
        if (pmAddr[20:9] != 12'h000) begin
            pmData = {1'h0, ~pmAddr[15:1]};
        end else if (pmAddr[8:1] == 8'h20) begin
            pmData = 16'hC123;
        end else if (pmAddr[8:1] == 8'h21) begin
            pmData = 16'hF456;
        end else begin
            pmData = {8'h10, pmAddr[8:1]};
        end
    end
endmodule : cfp_pmem_model

// ==== cfp_tb.sv ====
`timescale 1ns/1ps
module tb;
    logic clk_sys = 1'b0;
    logic arst_n = 1'b0;
    logic wbCyc = 1'b0;
    logic wbStb = 1'b0;
    logic wbWe = 1'b0;
    logic [7:0] wbAdr = 8'h00;
    logic [31:0] wbDatW = 32'h0;
    logic [31:0] wbDatR;
    logic wbAck;
    logic [20:0] pmAddr;
    logic [15:0] pmData;
    logic [3:0] phase;
    logic [15:0] instrRegister;
    logic execValid;
    logic [11:0] operandData;
    logic operandValid;
    logic dmRdStrobe;
    logic dmWrStrobe;
    cfp_pkg::cfp_br_t exBranchKind = cfp_pkg::BR_NONE;
    logic [19:0] exTargetWord = 20'h0;
    logic [10:0] exRelWords = 11'h0;
    logic exTwoWord = 1'b0;
    logic exSkip = 1'b0;
    logic exCallFast = 1'b0;
    logic exRetFast = 1'b0;
    logic intEntry = 1'b0;
    logic [19:0] intVectorWord = 20'h0;
    logic [23:0] cur = 24'h0;
    logic fastRestore;
    logic [7:0] rsS;
    logic [7:0] rsW;
    logic [7:0] rsB;
    int miscompares = 0;
    int n_compared = 0;
    int cycles = 0;
    logic [31:0] rd;
    logic [20:0] base;
    logic [20:0] tgt;
    logic [3:0] prev;

    always #50 clk_sys = ~clk_sys;

    cfp_fetch_core dut (
        .clk_sys(clk_sys), .arst_n(arst_n), .wb_cyc(wbCyc), .wb_stb(wbStb), .wb_we(wbWe),
        .wb_adr(wbAdr), .wb_sel(4'hF), .wb_dat_w(wbDatW), .wb_dat_r(wbDatR), .wb_ack(wbAck),
        .pmAddr(pmAddr), .pmData(pmData), .phase(phase), .instrRegister(instrRegister),
        .execValid(execValid), .operandData(operandData), .operandValid(operandValid),
        .dmRdStrobe(dmRdStrobe), .dmWrStrobe(dmWrStrobe), .exBranchKind(exBranchKind),
        .exTargetWord(exTargetWord), .exRelWords(exRelWords), .exTwoWord(exTwoWord),
        .exSkip(exSkip), .exCallFast(exCallFast), .exRetFast(exRetFast), .intEntry(intEntry),
        .intVectorWord(intVectorWord), .curStatus(cur[23:16]),
        .curWorkingAccumulator(cur[15:8]), .curBankSelectReg(cur[7:0]),
        .fastRestore(fastRestore), .restoreStatus(rsS), .restoreWorkingAccumulator(rsW),
        .restoreBankSelectReg(rsB)
    );

    cfp_pmem_model pmem (.pmAddr(pmAddr), .pmData(pmData));

    task automatic tally_and_finish();
        $display("compared %0d, mismatches %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : tally_and_finish

    // a hung handshake or phase wait ends here
    always @(posedge clk_sys) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            miscompares++;
            tally_and_finish();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            miscompares++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic wbXfer(input logic we, input logic [7:0] adr, input logic [31:0] dat);
        @(posedge clk_sys);
        wbCyc <= 1'b1;
        wbStb <= 1'b1;
        wbWe <= we;
        wbAdr <= adr;
        wbDatW <= dat;
        do @(posedge clk_sys); while (wbAck !== 1'b1);
        rd = wbDatR;
        wbCyc <= 1'b0;
        wbStb <= 1'b0;
        wbWe <= 1'b0;
    endtask : wbXfer

    task automatic wbRdChk(input logic [7:0] adr, input logic [31:0] exp);
        wbXfer(1'b0, adr, 32'h0);
        chk(rd, exp);
    endtask : wbRdChk

    // values seen at an edge are the ones that stood during the cycle it ends
    task automatic waitPhase(input logic [3:0] ph);
        do @(posedge clk_sys); while (phase !== ph);
    endtask : waitPhase

    // flags are {two word, fast call, fast return, interrupt entry}
    task automatic issue(input cfp_pkg::cfp_br_t kind, input logic [19:0] t,
                         input logic [10:0] rel, input logic [3:0] f);
        do @(posedge clk_sys);
        while (!(phase === cfp_pkg::PH_Q3 && (execValid === 1'b1 || operandValid === 1'b1)));
        base = pmAddr;
        exBranchKind <= kind;
        exTargetWord <= t;
        intVectorWord <= t;
        exRelWords <= rel;
        {exTwoWord, exCallFast, exRetFast, intEntry} <= f;
        @(posedge clk_sys);
        exBranchKind <= cfp_pkg::BR_NONE;
        {exTwoWord, exCallFast, exRetFast, intEntry} <= 4'h0;
    endtask : issue

    function automatic logic [15:0] expWord(input logic [20:0] a);
        return (a[20:9] != 12'h000) ? {1'h0, ~a[15:1]} : {8'h10, a[8:1]};
    endfunction : expWord

    task automatic checkJump(input logic [20:0] t, input logic [15:0] w);
        waitPhase(cfp_pkg::PH_Q2);
        chk(32'(pmAddr), 32'(t));
        chk(32'(execValid), 32'h0);
        waitPhase(cfp_pkg::PH_Q2);
        chk(32'(pmAddr), 32'(t + 21'h2));
        chk(32'(instrRegister), 32'(w));
    endtask : checkJump

    task automatic waitRestore(input logic [23:0] exp);
        int n;
        n = 0;
        @(posedge clk_sys);
        while (fastRestore !== 1'b1 && n < 8) begin
            n++;
            @(posedge clk_sys);
        end
        chk(32'(fastRestore), 32'h1);
        chk({8'h00, rsS, rsW, rsB}, {8'h00, exp});
    endtask : waitRestore

    initial begin
        repeat (20) @(posedge clk_sys);
        chk(32'(phase), 32'h1);
        chk(32'(pmAddr), 32'h0);
        arst_n <= 1'b1;
        waitPhase(cfp_pkg::PH_Q2);
        chk(32'(pmAddr), 32'h0);
        chk(32'(execValid), 32'h0);
        waitPhase(cfp_pkg::PH_Q2);
        chk(32'(execValid), 32'h1);
        chk(32'(instrRegister), 32'h1000);
        chk(32'(pmAddr), 32'h2);
        for (int i = 0; i < 16; i++) begin
            prev = phase;
            @(posedge clk_sys);
            chk(32'(phase), 32'({prev[2:0], prev[3]}));
            chk(32'(dmRdStrobe), 32'(phase === cfp_pkg::PH_Q2 && execValid === 1'b1));
            chk(32'(dmWrStrobe), 32'(phase === cfp_pkg::PH_Q4 && execValid === 1'b1));
        end
        wbRdChk(cfp_pkg::ADR_HLAT, 32'h0);
        wbRdChk(cfp_pkg::ADR_ULAT, 32'h0);
        wbRdChk(cfp_pkg::ADR_CTRL, 32'h1);
        $display("reset and phase test done");
        wbXfer(1'b1, cfp_pkg::ADR_ULAT, 32'h05);
        wbXfer(1'b1, cfp_pkg::ADR_HLAT, 32'h12);
        wbXfer(1'b1, cfp_pkg::ADR_PCLOW, 32'h35);
        // the write may land in either half of the cycle, so allow a few fetches
        for (int n = 0; n < 3 && pmAddr !== 21'h051234; n++) waitPhase(cfp_pkg::PH_Q2);
        chk(32'(pmAddr), 32'h051234);
        wbXfer(1'b1, cfp_pkg::ADR_HLAT, 32'h00);
        wbXfer(1'b1, cfp_pkg::ADR_ULAT, 32'h00);
        wbXfer(1'b0, cfp_pkg::ADR_PCLOW, 32'h0);
        chk(32'(rd[0]), 32'h0);
        wbRdChk(cfp_pkg::ADR_HLAT, 32'h12);
        wbRdChk(cfp_pkg::ADR_ULAT, 32'h05);
        wbXfer(1'b1, cfp_pkg::ADR_HLAT, 32'h77);
        wbXfer(1'b1, cfp_pkg::ADR_ULAT, 32'h1F);
        waitPhase(cfp_pkg::PH_Q2);
        waitPhase(cfp_pkg::PH_Q2);
        chk(32'(pmAddr[20:8]), 32'h0512);
        $display("latch test done");
        issue(cfp_pkg::BR_ABS, 20'h00100, 11'h0, 4'h0);
        checkJump(21'h000200, expWord(21'h000200));
        wbRdChk(cfp_pkg::ADR_HLAT, 32'h77);
        issue(cfp_pkg::BR_REL, 20'h0, 11'h005, 4'h0);
        tgt = base + 21'h00000A;
        checkJump(tgt, expWord(tgt));
        issue(cfp_pkg::BR_REL, 20'h0, 11'h7FE, 4'h0);
        tgt = base - 21'h000004;
        checkJump(tgt, expWord(tgt));
        $display("branch test done");
        issue(cfp_pkg::BR_ABS, 20'h00020, 11'h0, 4'h0);
        checkJump(21'h000040, 16'hC123);
        issue(cfp_pkg::BR_NONE, 20'h0, 11'h0, 4'b1000);
        waitPhase(cfp_pkg::PH_Q2);
        chk(32'(operandValid), 32'h1);
        chk(32'(operandData), 32'h456);
        chk(32'(execValid), 32'h0);
        waitPhase(cfp_pkg::PH_Q2);
        chk(32'(instrRegister), 32'h1022);
        issue(cfp_pkg::BR_ABS, 20'h00021, 11'h0, 4'h0);
        checkJump(21'h000042, 16'hF456);
        chk(32'(operandValid), 32'h0);
        chk(32'(execValid), 32'h0);
        // a skip over the first word leaves its second word to run alone
        issue(cfp_pkg::BR_ABS, 20'h0001F, 11'h0, 4'h0);
        checkJump(21'h00003E, 16'h101F);
        waitPhase(cfp_pkg::PH_Q3);
        exSkip <= 1'b1;
        @(posedge clk_sys);
        exSkip <= 1'b0;
        waitPhase(cfp_pkg::PH_Q2);
        chk(32'(instrRegister), 32'hC123);
        chk(32'(execValid | operandValid), 32'h0);
        waitPhase(cfp_pkg::PH_Q2);
        chk(32'(instrRegister), 32'hF456);
        chk(32'(execValid | operandValid), 32'h0);
        $display("two-word test done");
        cur <= 24'h112233;
        issue(cfp_pkg::BR_NONE, 20'h00008, 11'h0, 4'b0001);
        checkJump(21'h000010, 16'h1008);
        cur <= 24'h445566;
        issue(cfp_pkg::BR_NONE, 20'h0, 11'h0, 4'b0010);
        waitRestore(24'h112233);
        cur <= 24'hAABBCC;
        issue(cfp_pkg::BR_NONE, 20'h00008, 11'h0, 4'b0001);
        cur <= 24'h010203;
        issue(cfp_pkg::BR_NONE, 20'h00018, 11'h0, 4'b0001);
        cur <= 24'h000000;
        issue(cfp_pkg::BR_NONE, 20'h0, 11'h0, 4'b0010);
        waitRestore(24'h010203);
        cur <= 24'hD1D2D3;
        issue(cfp_pkg::BR_ABS, 20'h00030, 11'h0, 4'b0100);
        cur <= 24'h000000;
        for (logic [7:0] a = 8'h14; a < 8'h40; a += 8'h04) begin
            wbRdChk(a, 32'h0);
            wbXfer(1'b1, a, 32'hFF);
        end
        issue(cfp_pkg::BR_NONE, 20'h0, 11'h0, 4'b0010);
        waitRestore(24'hD1D2D3);
        $display("shadow test done");
        arst_n <= 1'b0;
        repeat (2) @(posedge clk_sys);
        chk(32'(pmAddr), 32'h0);
        chk(32'(execValid), 32'h0);
        arst_n <= 1'b1;
        waitPhase(cfp_pkg::PH_Q2);
        chk(32'(pmAddr), 32'h0);
        $display("second reset test done");
        tally_and_finish();
    end
endmodule : tb
